// ### core/bfps_top.sv
// Fault protection sequencer of a synchronous step-down converter
// Operation
// (RULE1) High side held off while valley overcurrent; not in OVP, where the min-on pulse ignores it
// (RULE2) Feedback under 68% flags, starts delay count
// (RULE3) After 1 ms undervoltage latch both drivers off
// (RULE4) Undervoltage check only after soft-start ends
// (RULE5) Over 120%: high off, low on
// (RULE6) At negative limit: low off, min on
// (RULE7) Cycle until undervoltage 1 ms, then hiccup
// (RULE8) Hiccup is 7x(pod+ss+uvd)+pod, 43 ms
// (RULE9) After hiccup, check overvoltage at soft-start end
// (RULE10) No overvoltage: restart start-up sequence
// (RULE11) Overcurrent shutdown leads to hiccup then retry
// (RULE12) Out-of-bounds at 8%: no fault, no latch
// (RULE13) Out-of-bounds: low-side forced PWM, negative limit; applied in RUN only, ignored during soft-start
// (RULE14) Supply lockout stops switching, non-latching
// (RULE15) Thermal shutdown stops switching, non-latching
// (RULE16) Lockout and thermal override all, reset counters
module bfps_top #(
  parameter int unsigned POD_CYC = bfps_pkg::POD_CYC,
  parameter int unsigned SS_CYC  = bfps_pkg::SS_CYC,
  parameter int unsigned UVD_CYC = bfps_pkg::UVD_CYC,
  parameter int unsigned HIC_CYC = bfps_pkg::HIC_CYC
) (
  // Clock, reset, enable
  input  wire  logic CLK_I,
  input  wire  logic NRST_I,
  input  wire  logic CE_I,
  // Comparator pins
  input  wire  logic OVERCURRENT_LIMIT_I,
  input  wire  logic UNDERVOLTAGE_CMP_I,
  input  wire  logic OVERVOLTAGE_CMP_I,
  input  wire  logic OUT_OF_BOUNDS_CMP_I,
  input  wire  logic NEG_CURRENT_LIMIT_I,
  input  wire  logic SUPPLY_LOCKOUT_I,
  input  wire  logic THERMAL_SHUTDOWN_I,
  // Regulator requests
  input  wire  logic REG_HS_REQ_I,
  input  wire  logic REG_LS_REQ_I,
  // Gate enables and status
  output logic       HS_EN_O,
  output logic       LS_EN_O,
  output logic       UNDERVOLTAGE_PROTECT_O,
  output logic       OVERVOLTAGE_PROTECT_O,
  output logic       OUT_OF_BOUNDS_DISCHARGE_O,
  output logic       SOFT_START_O,
  output logic       FAULT_LATCHED_O
);
  logic ocl_s, uv_s, ov_s, oob_s, neg_s, lock_s, therm_s;
  logic [6:0] pins;
  logic [6:0] syn;

  assign pins = {OVERCURRENT_LIMIT_I, UNDERVOLTAGE_CMP_I, OVERVOLTAGE_CMP_I,
                 OUT_OF_BOUNDS_CMP_I, NEG_CURRENT_LIMIT_I, SUPPLY_LOCKOUT_I,
                 THERMAL_SHUTDOWN_I};
  assign {ocl_s, uv_s, ov_s, oob_s, neg_s, lock_s, therm_s} = syn;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      bfps_sync u_sync (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .ce_i   (CE_I),
        .d_i    (pins[gi]),
        .q_o    (syn[gi])
      );
    end
  endgenerate

  localparam logic [bfps_pkg::CNT_W-1:0] POD_END = bfps_pkg::CNT_W'(POD_CYC - 1);
  localparam logic [bfps_pkg::CNT_W-1:0] SS_END  = bfps_pkg::CNT_W'(SS_CYC - 1);
  localparam logic [bfps_pkg::CNT_W-1:0] UVD_END = bfps_pkg::CNT_W'(UVD_CYC - 1);
  localparam logic [bfps_pkg::CNT_W-1:0] HIC_END = bfps_pkg::CNT_W'(HIC_CYC - 1);
  localparam logic [7:0] MINON_END = 8'(bfps_pkg::MIN_ON_CYC - 1);

  bfps_pkg::bfps_state_e state_reg;
  logic [bfps_pkg::CNT_W-1:0] cnt_reg;
  logic [bfps_pkg::CNT_W-1:0] uvd_reg;
  logic [7:0] minon_reg;
  logic       ovp_hs_reg;
  logic       shut;
  logic       uvd_done;
  logic       uv_armed;

  assign shut     = lock_s | therm_s; // see (RULE14) see (RULE15)
  assign uv_armed = (state_reg == bfps_pkg::BFPS_RUN) ||
                    (state_reg == bfps_pkg::BFPS_OVP); // see (RULE4)
  assign uvd_done = uv_armed && uv_s && (uvd_reg == UVD_END);

  // Undervoltage delay counter
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      uvd_reg <= '0;
    end else if (CE_I) begin
      if (shut || !uv_armed || !uv_s) begin
        uvd_reg <= '0; // see (RULE16)
      end else if (uvd_reg != UVD_END) begin
        uvd_reg <= uvd_reg + 1'b1; // see (RULE2)
      end
    end
  end

  // Sequence state and phase timer
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg <= bfps_pkg::BFPS_OFF;
      cnt_reg   <= '0;
    end else if (CE_I) begin
      cnt_reg <= cnt_reg + 1'b1;
      if (shut) begin
        state_reg <= bfps_pkg::BFPS_OFF; // see (RULE16)
        cnt_reg   <= '0;
      end else begin
        case (state_reg)
          bfps_pkg::BFPS_OFF: begin
            state_reg <= bfps_pkg::BFPS_POD;
            cnt_reg   <= '0;
          end
          bfps_pkg::BFPS_POD: begin
            if (cnt_reg == POD_END) begin
              state_reg <= bfps_pkg::BFPS_SS;
              cnt_reg   <= '0;
            end
          end
          bfps_pkg::BFPS_SS: begin
            if (cnt_reg == SS_END) begin
              state_reg <= bfps_pkg::BFPS_RUN;
              cnt_reg   <= '0;
            end
          end
          bfps_pkg::BFPS_RUN: begin
            if (uvd_done) begin
              state_reg <= bfps_pkg::BFPS_HICCUP; // see (RULE3) see (RULE11)
              cnt_reg   <= '0;
            end else if (ov_s) begin
              state_reg <= bfps_pkg::BFPS_OVP; // see (RULE5)
            end
          end
          bfps_pkg::BFPS_OVP: begin
            if (uvd_done) begin
              state_reg <= bfps_pkg::BFPS_HICCUP; // see (RULE7)
              cnt_reg   <= '0;
            end
          end
          bfps_pkg::BFPS_HICCUP: begin
            if (cnt_reg == HIC_END) begin
              state_reg <= bfps_pkg::BFPS_OVCHK; // see (RULE8)
              cnt_reg   <= '0;
            end
          end
          bfps_pkg::BFPS_OVCHK: begin
            if (cnt_reg == SS_END) begin
              cnt_reg <= '0;
              if (!ov_s) begin
                state_reg <= bfps_pkg::BFPS_POD; // see (RULE10)
              end
            end
          end
          default: begin
            state_reg <= bfps_pkg::BFPS_OFF;
          end
        endcase
      end
    end
  end

  // Overvoltage pull-down cycling with minimum on-time
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ovp_hs_reg <= 1'b0;
      minon_reg  <= '0;
    end else if (CE_I) begin
      if (state_reg != bfps_pkg::BFPS_OVP) begin
        ovp_hs_reg <= 1'b0;
        minon_reg  <= '0;
      end else if (ovp_hs_reg) begin
        minon_reg <= minon_reg + 1'b1;
        if (minon_reg == MINON_END) begin
          ovp_hs_reg <= 1'b0; // see (RULE6)
        end
      end else if (neg_s) begin
        ovp_hs_reg <= 1'b1; // see (RULE6)
        minon_reg  <= '0;
      end
    end
  end

  // Gate drive selection
  always_comb begin
    HS_EN_O = 1'b0;
    LS_EN_O = 1'b0;
    case (state_reg)
      bfps_pkg::BFPS_SS, bfps_pkg::BFPS_RUN: begin
        if (oob_s && state_reg == bfps_pkg::BFPS_RUN) begin
          LS_EN_O = !neg_s; // see (RULE12) see (RULE13)
        end else begin
          HS_EN_O = REG_HS_REQ_I && !ocl_s; // see (RULE1)
          LS_EN_O = REG_LS_REQ_I && !HS_EN_O;
        end
      end
      bfps_pkg::BFPS_OVP: begin
        HS_EN_O = ovp_hs_reg;
        LS_EN_O = !ovp_hs_reg && !neg_s; // see (RULE5)
      end
      bfps_pkg::BFPS_OVCHK: begin
        LS_EN_O = ov_s && !neg_s; // see (RULE9)
      end
      default: begin
        HS_EN_O = 1'b0;
        LS_EN_O = 1'b0;
      end
    endcase
    // State leaves RUN one edge late, so gates are cut here at once
    if (shut) begin
      HS_EN_O = 1'b0; // see (RULE14) see (RULE15)
      LS_EN_O = 1'b0; // see (RULE16)
    end
  end

  assign UNDERVOLTAGE_PROTECT_O    = uv_armed && uv_s; // see (RULE2)
  assign OVERVOLTAGE_PROTECT_O     = (state_reg == bfps_pkg::BFPS_OVP);
  assign OUT_OF_BOUNDS_DISCHARGE_O = (state_reg == bfps_pkg::BFPS_RUN) && oob_s;
  assign SOFT_START_O              = (state_reg == bfps_pkg::BFPS_SS);
  assign FAULT_LATCHED_O           = (state_reg == bfps_pkg::BFPS_HICCUP) ||
                                     (state_reg == bfps_pkg::BFPS_OVCHK);

  a_shut_drivers_off: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    shut |-> !HS_EN_O && !LS_EN_O) else $error("drivers on during shutdown"); // see (RULE16)
  a_ocl_hs_off: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    ocl_s && state_reg != bfps_pkg::BFPS_OVP |-> !HS_EN_O)
    else $error("high side on during overcurrent"); // see (RULE1)
  a_uv_not_in_ss: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SOFT_START_O |-> !UNDERVOLTAGE_PROTECT_O) else $error("undervoltage armed in soft-start"); // see (RULE4)
  a_uvd_to_hiccup: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CE_I && uvd_done && !shut |=> state_reg == bfps_pkg::BFPS_HICCUP)
    else $error("no latch-off after undervoltage delay"); // see (RULE3)
  a_hiccup_off: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    FAULT_LATCHED_O |-> !HS_EN_O && (!LS_EN_O || ov_s))
    else $error("driver on in hiccup"); // see (RULE7)
  a_ovp_hs_low: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CE_I && state_reg == bfps_pkg::BFPS_RUN && ov_s && !uvd_done && !shut |=> !HS_EN_O)
    else $error("high side not latched off on overvoltage"); // see (RULE5)
  a_ovp_min_on: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(ovp_hs_reg) && CE_I |-> ovp_hs_reg && !LS_EN_O)
    else $error("min on-time pulse broken"); // see (RULE6)
  a_oob_no_fault: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    OUT_OF_BOUNDS_DISCHARGE_O |-> !HS_EN_O && !FAULT_LATCHED_O)
    else $error("out-of-bounds drove high side"); // see (RULE13)
  a_ovchk_retry: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CE_I && !shut && state_reg == bfps_pkg::BFPS_OVCHK && cnt_reg == SS_END && !ov_s
    |=> state_reg == bfps_pkg::BFPS_POD) else $error("no restart after check"); // see (RULE10)
endmodule // bfps_top

// ### core/bfps_pkg.sv
// Constants for the buck fault protection sequencer
package bfps_pkg;
  localparam int unsigned CLK_HZ                = 25_000_000;
  // Times in microseconds
  localparam int unsigned POWER_ON_DELAY_US     = 1000;
  localparam int unsigned SOFT_START_US         = 4000;
  localparam int unsigned UNDERVOLTAGE_DELAY_US = 1000;
  localparam int unsigned HICCUP_MULT           = 7;
  localparam int unsigned HICCUP_US             = HICCUP_MULT *
    (POWER_ON_DELAY_US + SOFT_START_US + UNDERVOLTAGE_DELAY_US) + POWER_ON_DELAY_US;
  // Minimum on-time in nanoseconds
  localparam int unsigned MIN_ON_NS             = 120;
  localparam int unsigned CYC_PER_US            = CLK_HZ / 1_000_000;
  localparam int unsigned POD_CYC   = POWER_ON_DELAY_US * CYC_PER_US;
  localparam int unsigned SS_CYC    = SOFT_START_US * CYC_PER_US;
  localparam int unsigned UVD_CYC   = UNDERVOLTAGE_DELAY_US * CYC_PER_US;
  localparam int unsigned HIC_CYC   = HICCUP_US * CYC_PER_US;
  localparam int unsigned MIN_ON_CYC = (MIN_ON_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W     = 21;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic        SYNC_RESET_VAL = 1'b0;

  typedef enum logic [2:0] {
    BFPS_OFF, BFPS_POD, BFPS_SS, BFPS_RUN, BFPS_OVP, BFPS_HICCUP, BFPS_OVCHK
  } bfps_state_e;
endpackage

// ### core/bfps_sync.sv
// Three-stage pin synchroniser with agreement filter
module bfps_sync (
  // Clock and reset
  input  wire  logic clk_i,
  input  wire  logic nrst_i,
  input  wire  logic ce_i,
  // Pin
  input  wire  logic d_i,
  output logic       q_o
);
  logic [bfps_pkg::SYNC_STAGES-1:0] sh_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_reg <= '0;
    end else if (ce_i) begin
      sh_reg <= {sh_reg[bfps_pkg::SYNC_STAGES-2:0], d_i};
    end
  end

  // Change accepted once the second and third stages agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= bfps_pkg::SYNC_RESET_VAL;
    end else if (ce_i && (sh_reg[1] == sh_reg[2])) begin
      q_o <= sh_reg[2];
    end
  end
endmodule // bfps_sync

// ### tb/bfps_partner.sv
// Behavioural power stage that raises the negative current limit flag
module bfps_partner #(
  parameter int unsigned RAMP_CYC = 4
) (
  // Clock and reset
  input  wire  logic clk_i,
  input  wire  logic nrst_i,
  // Gate enable and comparator output
  input  wire  logic ls_en_i,
  output logic       neg_limit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned ramp;
  // Inductor current goes negative once the low side has conducted a while
  always @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ramp        <= 0;
      neg_limit_o <= 1'b0;
    end else if (ls_en_i) begin
      ramp        <= ramp + 1;
      neg_limit_o <= (ramp + 1 >= RAMP_CYC);
    end else begin
      ramp        <= 0;
      neg_limit_o <= 1'b0;
    end
  end
endmodule // bfps_partner

// ### tb/bfps_bench.sv
// Self-checking bench of the fault protection sequencer
module bfps_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POD = 10;
  localparam int SS  = 20;
  localparam int UVD = 10;
  localparam int HIC = 50;
  logic clk = 0, nrst = 0, ce = 1, overcurrent_limit = 0, uv = 0, ov = 0, out_of_bounds_discharge = 0;
  logic lockout = 0, therm = 0, hs_req = 0, ls_req = 0, neg;
  logic hs, ls, undervoltage_protect, overvoltage_protect, oobd, ss, flt;
  integer seed = 32'h4254;
  int errors = 0, checked = 0, n;
  always #20 clk = ~clk;
  bfps_top #(.POD_CYC(POD), .SS_CYC(SS), .UVD_CYC(UVD), .HIC_CYC(HIC)) uut (
    .CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .OVERCURRENT_LIMIT_I(overcurrent_limit),
    .UNDERVOLTAGE_CMP_I(uv), .OVERVOLTAGE_CMP_I(ov), .OUT_OF_BOUNDS_CMP_I(out_of_bounds_discharge),
    .NEG_CURRENT_LIMIT_I(neg), .SUPPLY_LOCKOUT_I(lockout), .THERMAL_SHUTDOWN_I(therm),
    .REG_HS_REQ_I(hs_req), .REG_LS_REQ_I(ls_req), .HS_EN_O(hs), .LS_EN_O(ls),
    .UNDERVOLTAGE_PROTECT_O(undervoltage_protect), .OVERVOLTAGE_PROTECT_O(overvoltage_protect),
    .OUT_OF_BOUNDS_DISCHARGE_O(oobd), .SOFT_START_O(ss), .FAULT_LATCHED_O(flt));
  bfps_partner partner (.clk_i(clk), .nrst_i(nrst), .ls_en_i(ls), .neg_limit_o(neg));
  logic [2:0] neg_sh;
  logic       neg_q;
  // Limit flag as the block sees it after its pin filter latency
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      neg_sh <= 3'h0;
      neg_q  <= 1'b0;
    end else if (ce) begin
      neg_sh <= {neg_sh[1:0], neg};
      if (neg_sh[1] == neg_sh[2]) neg_q <= neg_sh[2];
    end
  end
  function automatic logic near(int got, int exp);
    return (got >= exp - 2) && (got <= exp + 3);
  endfunction
  function automatic logic exp_ls(logic ovc, logic negc);
    return ovc & ~negc;
  endfunction
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
    if (s !== v) begin
      chk(s, v);
      complete_run();
    end
  endtask
  task automatic dur(ref logic s, output int cnt);
    cnt = 0;
    while (s === 1'b1 && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
    if (s === 1'b1) begin
      chk(s, 1'b0);
      complete_run();
    end
  endtask
  task automatic rand_run(input logic oc);
    overcurrent_limit = oc;
    repeat (6) @(negedge clk);
    repeat (20) begin
      @(negedge clk);
      hs_req = $random(seed);
      ls_req = $random(seed);
      #1 chk(hs, hs_req & ~oc);
      chk(ls, ls_req & ~(hs_req & ~oc));
    end
    overcurrent_limit = 0;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1;
    wait_lvl(ss, 1'b1, POD + 10);
    uv = 1;
    repeat (8) @(negedge clk);
    chk(undervoltage_protect, 1'b0);
    chk(flt, 1'b0);
    uv = 0;
    dur(ss, n);
    rand_run(1'b0);
    rand_run(1'b1);
    hs_req = 1;
    ls_req = 0;
    out_of_bounds_discharge = 1;
    wait_lvl(oobd, 1'b1, 10);
    repeat (10) begin
      @(negedge clk);
      chk(hs, 1'b0);
      chk(ls, ~neg_q);
      chk(flt | overvoltage_protect, 1'b0);
    end
    out_of_bounds_discharge = 0;
    wait_lvl(oobd, 1'b0, 10);
    uv = 1;
    wait_lvl(undervoltage_protect, 1'b1, 10);
    n = 0;
    while (flt !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(near(n, UVD), 1'b1);
    chk(hs | ls, 1'b0);
    uv = 0;
    dur(flt, n);
    chk(near(n, HIC + SS), 1'b1);
    wait_lvl(ss, 1'b1, POD + 6);
    dur(ss, n);
    chk(near(n, SS), 1'b1);
    ov = 1;
    wait_lvl(overvoltage_protect, 1'b1, 10);
    chk(hs, 1'b0);
    chk(ls, 1'b1);
    wait_lvl(hs, 1'b1, 20);
    dur(hs, n);
    chk(n == bfps_pkg::MIN_ON_CYC, 1'b1);
    ov = 0;
    uv = 1;
    wait_lvl(flt, 1'b1, UVD + 60);
    chk(hs | ls, 1'b0);
    uv = 0;
    ov = 1;
    repeat (HIC + 4) @(negedge clk);
    repeat (SS - 6) begin
      @(negedge clk);
      chk(ls, exp_ls(ov, neg_q));
    end
    repeat (SS) @(negedge clk);
    chk(flt, 1'b1);
    ov = 0;
    wait_lvl(ss, 1'b1, 2 * SS + POD + 10);
    // Frozen enable stretches soft-start by the frozen cycles
    ce = 0;
    repeat (5) @(negedge clk);
    ce = 1;
    dur(ss, n);
    chk(near(n, SS), 1'b1);
    for (int k = 0; k < 2; k++) begin
      wait_lvl(ss, 1'b0, SS + 10);
      hs_req = 1;
      ls_req = 1;
      if (k == 0) lockout = 1;
      else therm = 1;
      repeat (8) @(negedge clk);
      chk(hs | ls, 1'b0);
      chk(flt | ss, 1'b0);
      lockout = 0;
      therm = 0;
      wait_lvl(ss, 1'b1, POD + 12);
    end
    complete_run();
  end
endmodule // bfps_bench
